// >>> lbr_pkg.sv
// Constants and helpers shared by the local bus receiver modules.
// Assumes a single 20 MHz clock and an asynchronous active-high reset.
// Functional notes
// - Among slots requesting on one level, the slot nearest the controller wins.
// - Competing DMA requests are granted first to the slot nearest the controller.
// - Sixteen memory address registers serve the local DMA transfers.
// - The receiver supplies every DMA memory address; slots never drive one.
// - The local bus can be cut off from the main bus.
// - The local bus signals like the main bus, separated only by switches; here the receiver re-drives it and synchronises its inputs.
// - Only levels 15, 13, 12, 11 and 10 have request lines.
// - An identify request returns the 9-bit code of the winning slot.
// - Level 15 has no identify cycle; software reads a status word instead.
// - Each programmed transfer is selected by an 11-bit register address.
// - Control load, status read and data buffer access each have an address.
// - DMA setup is written and status read through programmed transfers.
// - A request is raised each time a slot is ready for the next transfer.
// - The DMA channel moves up to one million words per second.
// - Changing DMA service between slots adds no idle channel cycles.
// - External requests set only pending bits 15, 13, 12, 11 and 10.
package lbr_pkg;
    localparam int NSLOT_DEF = 8;
    localparam int DATA_W = 16;
    localparam int DRA_W = 11;
    localparam int IDENT_W = 9;
    localparam int NCHAN = 16;
    localparam int CHAN_W = 4;
    localparam int NLVL = 5;
    // Lines 0 to 3 carry levels 10 to 13; line 4 carries level 15.
    localparam int LINE_FAST = 4;
    localparam int LVL_BASE_N = 10;
    localparam int LVL_FAST_N = 15;
    localparam logic [3:0] LVL_BASE = 4'ha;
    localparam logic [3:0] LVL_TOP = 4'hd;
    localparam logic [3:0] LVL_FAST = 4'hf;
    localparam logic [15:0] EXT_LVL_MASK = 16'hbc00;
    localparam logic [DRA_W-1:0] RCV_DRA_BASE = 11'h7c0;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h01;
    localparam logic [4:0] OFS_DATA = 5'h02;
    localparam int OFS_ADDR_BIT = 4;
    localparam int CTL_DISC = 0;
    localparam int CTL_IRQ_EN = 1;
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0002;
    localparam int CLK_NS = 50;
    localparam int PIO_TMO_NS = 2000;
    localparam int PIO_TMO_CYC = (PIO_TMO_NS + CLK_NS - 1) / CLK_NS;
    localparam int GNT_HOLD = 3;

    // Index of the lowest set bit; the caller checks that one is set.
    function automatic logic [4:0] lbr_first(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction
endpackage

// >>> lbr_if.sv
// Arbiter and address bank signals between the receiver modules.
// Assumes all three modules share one clock.
`timescale 1ns/10ps
interface lbr_if #(
    parameter int N = 8
);
    import lbr_pkg::*;
    logic [N-1:0]        req;
    logic [N-1:0]        busy;
    logic                take;
    logic                valid;
    logic [N-1:0]        gnt;
    logic                wr_en;
    logic [CHAN_W-1:0]   wr_idx;
    logic [DATA_W-1:0]   wr_data;
    logic                inc_en;
    logic [CHAN_W-1:0]   inc_idx;
    logic [CHAN_W-1:0]   rd_idx;
    logic [DATA_W-1:0]   rd_data;
    logic [CHAN_W-1:0]   sw_idx;
    logic [DATA_W-1:0]   sw_data;
    modport arb (input req, busy, take, output valid, gnt);
    modport bank (input wr_en, wr_idx, wr_data, inc_en, inc_idx, rd_idx, sw_idx, output rd_data, sw_data);
    modport top (output req, busy, take, wr_en, wr_idx, wr_data, inc_en, inc_idx, rd_idx, sw_idx,
                 input valid, gnt, rd_data, sw_data);
endinterface

// >>> lbr_arb.sv
// Fixed-position DMA arbiter: slot 0 sits nearest the controller.
// Assumes requests arrive already synchronised to mclk.
`timescale 1ns/10ps
module lbr_arb #(
    parameter int N = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Requests and grant
    lbr_if.arb       a
);
    import lbr_pkg::*;

    typedef struct packed {
        logic [N-1:0][1:0] hold;
    } lbr_arb_st_t;

    lbr_arb_st_t  st_ff;
    lbr_arb_st_t  nxt_st;
    logic [N-1:0] free;
    logic [N-1:0] elig;

    // A granted slot keeps its request up until its drop has crossed the synchroniser,
    // so it is held off for that long rather than granted twice.
    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < N; i++) begin
            free[i] = (st_ff.hold[i] == 2'h0);
            if (!free[i]) begin
                nxt_st.hold[i] = st_ff.hold[i] - 2'h1;
            end
            if (a.take && a.busy[i]) begin
                nxt_st.hold[i] = 2'(GNT_HOLD);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign elig = a.req & ~a.busy & free;
    assign a.valid = |elig;
    assign a.gnt = elig & (~elig + 1'b1);

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_arb_nearest;
        a.valid |-> ((elig & (a.gnt - 1'b1)) == '0) && ((a.gnt & elig) == a.gnt) && $onehot(a.gnt);
    endproperty
    a_arb_nearest: assert property (p_arb_nearest) else $error("grant not to nearest slot");

    property p_arb_hold;
        a.take && (a.busy != '0) |=> ((a.gnt & $past(a.busy)) == '0);
    endproperty
    a_arb_hold: assert property (p_arb_hold) else $error("slot regranted during holdoff");
endmodule // lbr_arb

// >>> lbr_bank.sv
// Bank of DMA memory address registers with a software port and a DMA port.
// Assumes write and increment requests are single-cycle strobes on mclk.
`timescale 1ns/10ps
module lbr_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register access
    lbr_if.bank      b
);
    import lbr_pkg::*;

    typedef struct packed {
        logic [NCHAN-1:0][DATA_W-1:0] addr;
    } lbr_bank_st_t;

    lbr_bank_st_t      st_ff;
    lbr_bank_st_t      nxt_st;
    logic [DATA_W-1:0] inc_old;

    // A software reload wins over an increment of the same register.
    always_comb begin
        nxt_st = st_ff;
        inc_old = st_ff.addr[b.inc_idx];
        if (b.inc_en) begin
            nxt_st.addr[b.inc_idx] = inc_old + 1'b1;
        end
        if (b.wr_en) begin
            nxt_st.addr[b.wr_idx] = b.wr_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign b.rd_data = st_ff.addr[b.rd_idx];
    assign b.sw_data = st_ff.addr[b.sw_idx];

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_bank_inc;
        b.inc_en && !(b.wr_en && (b.wr_idx == b.inc_idx)) |=>
            st_ff.addr[$past(b.inc_idx)] == $past(inc_old) + 1'b1;
    endproperty
    a_bank_inc: assert property (p_bank_inc) else $error("address register did not step");
endmodule // lbr_bank

// >>> lbr_top.sv
// Local bus receiver: passes programmed transfers, runs DMA from its address bank,
// ranks interrupts by slot and answers identify requests.
// Main-bus side signals share mclk; every local-bus input is treated as asynchronous.
`timescale 1ns/10ps
module lbr_top #(
    parameter int                        NSLOT   = lbr_pkg::NSLOT_DEF,
    parameter logic [lbr_pkg::DRA_W-1:0] OWN_DRA = lbr_pkg::RCV_DRA_BASE
) (
    // Clock and reset
    input  wire logic                                                 mclk,
    input  wire logic                                                 rst,
    // Main bus programmed transfers
    input  wire logic                                                 pio_req,
    input  wire logic                                                 pio_we,
    input  wire logic [lbr_pkg::DRA_W-1:0]                            pio_dra,
    input  wire logic [lbr_pkg::DATA_W-1:0]                           pio_wdata,
    output logic                                                      pio_busy,
    output logic                                                      pio_ack,
    output logic [lbr_pkg::DATA_W-1:0]                                pio_rdata,
    // Main bus identification
    input  wire logic                                                 idn_req,
    input  wire logic [3:0]                                           idn_level,
    output logic                                                      idn_ack,
    output logic [lbr_pkg::IDENT_W-1:0]                               idn_code,
    // Main bus pending level requests
    output logic [15:0]                                               pending_level_bits,
    // Main bus memory port
    output logic                                                      mem_req,
    output logic                                                      mem_we,
    output logic [lbr_pkg::DATA_W-1:0]                                mem_addr,
    output logic [lbr_pkg::DATA_W-1:0]                                mem_wdata,
    input  wire logic                                                 mem_ack,
    input  wire logic [lbr_pkg::DATA_W-1:0]                           mem_rdata,
    // Isolation switches
    input  wire logic                                                 bus_disconnect,
    output logic                                                      loc_bus_en,
    // Local bus programmed transfers
    output logic                                                      loc_pio_req,
    output logic                                                      loc_we,
    output logic [lbr_pkg::DRA_W-1:0]                                 loc_dra,
    output logic [lbr_pkg::DATA_W-1:0]                                loc_wdata,
    input  wire logic                                                 loc_ack,
    input  wire logic [lbr_pkg::DATA_W-1:0]                           loc_rdata,
    // Local bus interrupts and identification
    input  wire logic [lbr_pkg::NLVL-1:0][NSLOT-1:0]                  slot_irq,
    input  wire logic [NSLOT-1:0][lbr_pkg::IDENT_W-1:0]               slot_ident,
    // Local bus DMA
    input  wire logic [NSLOT-1:0]                                     slot_dma_req,
    input  wire logic [NSLOT-1:0]                                     slot_dma_we,
    input  wire logic [NSLOT-1:0][lbr_pkg::CHAN_W-1:0]                slot_dma_chan,
    input  wire logic [NSLOT-1:0][lbr_pkg::DATA_W-1:0]                slot_dma_wdata,
    output logic [NSLOT-1:0]                                          slot_dma_gnt,
    output logic [lbr_pkg::DATA_W-1:0]                                loc_dma_rdata
);
    import lbr_pkg::*;

    localparam int SW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
    localparam int TW = $clog2(PIO_TMO_CYC + 1);

    typedef struct packed {
        logic                          disc;
        logic                          ack;
        logic [DATA_W-1:0]             rdata;
        logic [NLVL-1:0][NSLOT-1:0]    irq;
        logic [NSLOT-1:0][IDENT_W-1:0] ident;
        logic [NSLOT-1:0]              dreq;
        logic [NSLOT-1:0]              dwe;
        logic [NSLOT-1:0][CHAN_W-1:0]  dchan;
        logic [NSLOT-1:0][DATA_W-1:0]  dwdata;
    } lbr_pins_t;

    typedef enum logic [1:0] {
        PIO_IDLE    = 2'b00,
        PIO_LOCAL   = 2'b01,
        PIO_RELEASE = 2'b10
    } lbr_pio_t;

    typedef struct packed {
        lbr_pins_t          s1;
        lbr_pins_t          s2;
        lbr_pio_t           pio;
        logic [TW-1:0]      tmo;
        logic [DATA_W-1:0]  ctrl;
        logic [DATA_W-1:0]  last_id;
        logic               pio_ack;
        logic [DATA_W-1:0]  pio_rdata;
        logic               loc_req;
        logic               loc_we;
        logic [DRA_W-1:0]   loc_dra;
        logic [DATA_W-1:0]  loc_wdata;
        logic               idn_ack;
        logic [IDENT_W-1:0] idn_code;
        logic [15:0]        lvl;
        logic               mem_req;
        logic               mem_we;
        logic [DATA_W-1:0]  mem_addr;
        logic [DATA_W-1:0]  mem_wdata;
        logic [SW-1:0]      slot;
        logic [CHAN_W-1:0]  chan;
        logic [NSLOT-1:0]   gnt;
        logic [DATA_W-1:0]  dma_rdata;
    } lbr_st_t;

    lbr_st_t                    st_ff;
    lbr_st_t                    nxt;
    lbr_pins_t                  pins;
    logic                       disc;
    logic [NLVL-1:0][NSLOT-1:0] irq_v;
    logic [NLVL-1:0]            line_any;
    logic                       own;
    logic [4:0]                 ofs;
    logic [DATA_W-1:0]          own_rd;
    logic                       id_in_range;
    logic [NSLOT-1:0]           id_vec;
    logic                       lvl_any;
    logic [IDENT_W-1:0]         id_code;
    logic                       done;
    logic                       launch;
    logic [SW-1:0]              win;
    logic [CHAN_W-1:0]          win_chan;
    logic [DATA_W-1:0]          win_addr;

    lbr_if #(.N(NSLOT)) u_if ();

    lbr_arb #(
        .N    (NSLOT)
    ) u_arb (
        .mclk (mclk),
        .rst  (rst),
        .a    (u_if.arb)
    );

    lbr_bank u_bank (
        .mclk (mclk),
        .rst  (rst),
        .b    (u_if.bank)
    );

    assign pins = '{disc: bus_disconnect, ack: loc_ack, rdata: loc_rdata, irq: slot_irq,
                    ident: slot_ident, dreq: slot_dma_req, dwe: slot_dma_we,
                    dchan: slot_dma_chan, dwdata: slot_dma_wdata};

    // Isolation acts on the synchronised view, so a babbling slot never reaches the main bus.
    assign disc = st_ff.s2.disc | st_ff.ctrl[CTL_DISC];
    assign loc_bus_en = ~disc;

    always_comb begin
        for (int l = 0; l < NLVL; l++) begin
            irq_v[l] = disc ? '0 : st_ff.s2.irq[l];
            line_any[l] = |irq_v[l];
        end
    end

    // Own register decode and read mux.
    assign own = (pio_dra[DRA_W-1:5] == OWN_DRA[DRA_W-1:5]);
    assign ofs = pio_dra[4:0];
    assign u_if.sw_idx = ofs[CHAN_W-1:0];

    always_comb begin
        own_rd = '0;
        if (ofs[OFS_ADDR_BIT]) begin
            own_rd = u_if.sw_data;
        end else if (ofs == OFS_CTRL) begin
            own_rd = st_ff.ctrl;
        end else if (ofs == OFS_STAT) begin
            own_rd = {9'h000, st_ff.mem_req, disc, line_any};
        end else if (ofs == OFS_DATA) begin
            own_rd = st_ff.last_id;
        end
    end

    // Identify: only levels 10 to 13 have a cycle; level 15 and unknown levels read zero.
    assign id_in_range = (idn_level >= LVL_BASE) && (idn_level <= LVL_TOP);
    assign id_vec = id_in_range ? irq_v[int'(idn_level - LVL_BASE)] : '0;
    assign lvl_any = |id_vec;
    assign id_code = lvl_any ? st_ff.s2.ident[SW'(lbr_first(32'(id_vec)))] : '0;

    // DMA launch: a new word may start in the cycle the previous one completes.
    assign done = st_ff.mem_req && mem_ack;
    assign launch = (!st_ff.mem_req || mem_ack) && u_if.valid && !disc;
    assign win = SW'(lbr_first(32'(u_if.gnt)));
    assign win_chan = st_ff.s2.dchan[win];
    assign u_if.rd_idx = win_chan;
    // Bypass the step of a register that completes in this very cycle.
    assign win_addr = (done && (st_ff.chan == win_chan)) ? u_if.rd_data + 1'b1 : u_if.rd_data;
    assign u_if.req = disc ? '0 : st_ff.s2.dreq;
    assign u_if.busy = st_ff.mem_req ? (NSLOT'(1) << st_ff.slot) : '0;
    assign u_if.take = done;
    assign u_if.inc_en = done;
    assign u_if.inc_idx = st_ff.chan;
    assign u_if.wr_idx = ofs[CHAN_W-1:0];
    assign u_if.wr_data = pio_wdata;
    assign u_if.wr_en = (st_ff.pio == PIO_IDLE) && pio_req && own && pio_we && ofs[OFS_ADDR_BIT];

    always_comb begin
        nxt = st_ff;
        nxt.s1 = pins;
        nxt.s2 = st_ff.s1;
        nxt.pio_ack = 1'b0;
        nxt.idn_ack = 1'b0;
        nxt.gnt = '0;
        unique case (st_ff.pio)
            PIO_IDLE: begin
                if (pio_req && own) begin
                    nxt.pio_ack = 1'b1;
                    nxt.pio_rdata = pio_we ? '0 : own_rd;
                    if (pio_we && (ofs == OFS_CTRL)) begin
                        nxt.ctrl = pio_wdata;
                    end
                end else if (pio_req && disc) begin
                    nxt.pio_ack = 1'b1;
                    nxt.pio_rdata = '0;
                end else if (pio_req) begin
                    nxt.pio = PIO_LOCAL;
                    nxt.loc_req = 1'b1;
                    nxt.loc_we = pio_we;
                    nxt.loc_dra = pio_dra;
                    nxt.loc_wdata = pio_wdata;
                    nxt.tmo = '0;
                end
            end
            PIO_LOCAL: begin
                nxt.tmo = st_ff.tmo + 1'b1;
                if (st_ff.s2.ack && !disc) begin
                    nxt.pio_ack = 1'b1;
                    nxt.pio_rdata = st_ff.loc_we ? '0 : st_ff.s2.rdata;
                    nxt.loc_req = 1'b0;
                    nxt.pio = PIO_RELEASE;
                end else if (disc || (st_ff.tmo == TW'(PIO_TMO_CYC - 1))) begin
                    // An absent slot must not hang the processor; the read returns zero.
                    nxt.pio_ack = 1'b1;
                    nxt.pio_rdata = '0;
                    nxt.loc_req = 1'b0;
                    nxt.pio = PIO_RELEASE;
                end
            end
            PIO_RELEASE: begin
                if (!st_ff.s2.ack || disc) begin
                    nxt.pio = PIO_IDLE;
                end
            end
            default: begin
                nxt.pio = PIO_IDLE;
                nxt.loc_req = 1'b0;
            end
        endcase
        if (idn_req) begin
            nxt.idn_ack = 1'b1;
            nxt.idn_code = id_code;
            nxt.last_id = DATA_W'(id_code);
        end
        // Requests follow the slot lines level for level, so a serviced slot clears them.
        nxt.lvl = '0;
        if (st_ff.ctrl[CTL_IRQ_EN]) begin
            for (int l = 0; l < LINE_FAST; l++) begin
                nxt.lvl[LVL_BASE_N + l] = line_any[l];
            end
            nxt.lvl[LVL_FAST_N] = line_any[LINE_FAST];
        end
        if (done) begin
            nxt.mem_req = 1'b0;
            nxt.dma_rdata = mem_rdata;
            nxt.gnt = disc ? '0 : (NSLOT'(1) << st_ff.slot);
        end
        if (launch) begin
            nxt.mem_req = 1'b1;
            nxt.slot = win;
            nxt.chan = win_chan;
            nxt.mem_addr = win_addr;
            nxt.mem_we = st_ff.s2.dwe[win];
            nxt.mem_wdata = st_ff.s2.dwdata[win];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RST;
        end else begin
            st_ff <= nxt;
        end
    end

    assign pio_busy = (st_ff.pio != PIO_IDLE);
    assign pio_ack = st_ff.pio_ack;
    assign pio_rdata = st_ff.pio_rdata;
    assign idn_ack = st_ff.idn_ack;
    assign idn_code = st_ff.idn_code;
    assign pending_level_bits = st_ff.lvl;
    assign mem_req = st_ff.mem_req;
    assign mem_we = st_ff.mem_we;
    assign mem_addr = st_ff.mem_addr;
    assign mem_wdata = st_ff.mem_wdata;
    assign loc_pio_req = st_ff.loc_req;
    assign loc_we = st_ff.loc_we;
    assign loc_dra = st_ff.loc_dra;
    assign loc_wdata = st_ff.loc_wdata;
    assign slot_dma_gnt = st_ff.gnt;
    assign loc_dma_rdata = st_ff.dma_rdata;

    localparam int P_WAIT = 48;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_lvl_ext;
        (pending_level_bits & ~EXT_LVL_MASK) == '0;
    endproperty
    a_lvl_ext: assert property (p_lvl_ext) else $error("pending bit outside external levels");

    property p_id_fast;
        idn_req && (idn_level == LVL_FAST) |=> idn_ack && (idn_code == '0);
    endproperty
    a_id_fast: assert property (p_id_fast) else $error("level 15 answered an identify");

    property p_id_ack;
        idn_req |=> idn_ack ##1 !idn_ack || $past(idn_req);
    endproperty
    a_id_ack: assert property (p_id_ack) else $error("identify not answered in one cycle");

    property p_id_none;
        idn_req && !lvl_any |=> idn_code == '0;
    endproperty
    a_id_none: assert property (p_id_none) else $error("nonzero code with no requester");

    property p_disc;
        disc |=> !loc_pio_req && (slot_dma_gnt == '0);
    endproperty
    a_disc: assert property (p_disc) else $error("local bus active while isolated");

    property p_pio_done;
        pio_req && !pio_busy |-> ##[1:P_WAIT] pio_ack;
    endproperty
    a_pio_done: assert property (p_pio_done) else $error("programmed transfer never acknowledged");

    property p_b2b;
        done && u_if.valid && !disc |=> mem_req;
    endproperty
    a_b2b: assert property (p_b2b) else $error("idle cycle between DMA slots");

    property p_gnt;
        done && !disc |=> $onehot(slot_dma_gnt) ##1 (slot_dma_gnt == '0) || $past(done);
    endproperty
    a_gnt: assert property (p_gnt) else $error("DMA word completed without one grant");

    c_b2b: cover property (done && launch);
    c_id_hit: cover property (idn_req && lvl_any);
    c_tmo: cover property ((st_ff.pio == PIO_LOCAL) && (st_ff.tmo == TW'(PIO_TMO_CYC - 1)));
    c_disc: cover property ($rose(disc));
endmodule // lbr_top

// >>> lbr_slot_model.sv
// Behavioural slot answering local programmed transfers on the local bus.
// Assumes it shares mclk with the receiver and that the request stays up until it is acknowledged.
`timescale 1ns/10ps
module lbr_slot_model (
    // Clock
    input  wire logic        mclk,
    // Local bus
    input  wire logic        loc_pio_req,
    input  wire logic [10:0] loc_dra,
    output logic             loc_ack,
    output logic [15:0]      loc_rdata
);
    logic [1:0] dly_ff;
    // Two cycles of latency make the receiver's synchroniser do real work.
    always_ff @(posedge mclk) dly_ff <= loc_pio_req ? {dly_ff[0], 1'b1} : 2'h0;
    assign loc_ack = dly_ff[1];
    // Released data lines show the inverse, so a stale sample cannot pass for a match.
    assign loc_rdata = loc_ack ? {5'h15, loc_dra} : ~{5'h15, loc_dra};
endmodule // lbr_slot_model

// >>> local_io_bus_receiver_tb.sv
// Self-checking bench for the local bus receiver with a slot model on the local side.
// Assumes the default slot count of eight and the default own register address.
`timescale 1ns/10ps
module local_io_bus_receiver_tb;
    import lbr_pkg::*;
    logic mclk = 0, rst = 1, pio_req = 0, pio_we = 0, idn_req = 0, mem_ack = 0, bus_disconnect = 0;
    logic pio_busy, pio_ack, idn_ack, mem_req, mem_we, loc_bus_en, loc_pio_req, loc_we, loc_ack;
    logic [DRA_W-1:0] pio_dra = 0, loc_dra;
    logic [3:0] idn_level = 0;
    logic [IDENT_W-1:0] idn_code;
    logic [15:0] pio_wdata = 0, pio_rdata, pending_level_bits, mem_addr, mem_wdata, mem_rdata = 0;
    logic [15:0] loc_wdata, loc_rdata, loc_dma_rdata;
    logic [NLVL-1:0][7:0] slot_irq = 0;
    logic [7:0][IDENT_W-1:0] slot_ident = 0;
    logic [7:0] slot_dma_req = 0, slot_dma_we = 0, slot_dma_gnt;
    logic [7:0][CHAN_W-1:0] slot_dma_chan = 0;
    logic [7:0][15:0] slot_dma_wdata = 0;
    int n_mismatch = 0, checks = 0;
    always #25 mclk = ~mclk;
    lbr_top #(.NSLOT(8)) i_dut (.mclk, .rst, .pio_req, .pio_we, .pio_dra, .pio_wdata, .pio_busy, .pio_ack,
        .pio_rdata, .idn_req, .idn_level, .idn_ack, .idn_code, .pending_level_bits, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .bus_disconnect, .loc_bus_en, .loc_pio_req, .loc_we,
        .loc_dra, .loc_wdata, .loc_ack, .loc_rdata, .slot_irq, .slot_ident, .slot_dma_req, .slot_dma_we,
        .slot_dma_chan, .slot_dma_wdata, .slot_dma_gnt, .loc_dma_rdata);
    lbr_slot_model i_slot (.mclk, .loc_pio_req, .loc_dra, .loc_ack, .loc_rdata);
    task automatic close_out;
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pio(input logic we, input logic [10:0] device_register_address, input logic [15:0] wd, output logic [15:0] r);
        @(posedge mclk);
        pio_req <= 1'b1;
        pio_we <= we;
        pio_dra <= device_register_address;
        pio_wdata <= wd;
        @(posedge mclk);
        pio_req <= 1'b0;
        #1;
        for (int i = 0; i < 60 && pio_ack !== 1'b1; i++) @(posedge mclk) #1;
        chk(16'(pio_ack), 16'h1);
        r = pio_rdata;
        while (pio_busy === 1'b1) @(posedge mclk) #1;
    endtask
    task automatic idn(input logic [3:0] lv, input logic [8:0] exp);
        @(posedge mclk);
        idn_req <= 1'b1;
        idn_level <= lv;
        @(posedge mclk);
        idn_req <= 1'b0;
        #1 chk({6'h0, idn_ack, idn_code}, {7'h1, exp});
    endtask
    // Ident of the requesting slot nearest the controller, zero when nobody asks.
    function automatic logic [8:0] first_id(input logic [7:0] m);
        for (int i = 0; i < 8; i++) if (m[i]) return slot_ident[i];
        return 9'h0;
    endfunction
    initial begin
        logic [10:0] d;
        logic [15:0] r;
        logic [15:0] wv;
        logic [7:0] m;
        int s;
        void'($urandom(4));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) slot_ident[i] <= 9'($urandom);
        slot_dma_we <= 8'($urandom);
        slot_dma_wdata <= 128'({$urandom, $urandom, $urandom, $urandom});
        mem_rdata <= 16'($urandom);
        for (int i = 0; i < 6; i++) begin
            d = 11'($urandom_range(11'h7bf));
            wv = 16'($urandom);
            pio(i[0], d, wv, r);
            chk(r, i[0] ? 16'h0 : {5'h15, d});
            chk(loc_wdata, wv);
            chk(16'(loc_we), 16'(i[0]));
        end
        for (int l = 0; l < 5; l++) begin
            m = (l == 1) ? 8'h06 : 8'($urandom_range(255, 1));
            slot_irq[l] <= m;
            repeat (4) @(posedge mclk);
            #1 chk(pending_level_bits, l == 4 ? 16'h8000 : 16'h1 << (10 + l));
            idn(l == 4 ? 4'hf : 4'(10 + l), l == 4 ? 9'h0 : first_id(m));
            slot_irq[l] <= 8'h0;
        end
        repeat (4) @(posedge mclk);
        idn(4'hc, 9'h0);
        idn(4'he, 9'h0);
        for (int c = 0; c < 16; c++) begin
            pio(1'b1, 11'h7d0 + 11'(c), {4'(c), 12'h0ab}, r);
            pio(1'b0, 11'h7d0 + 11'(c), 16'h0, r);
            chk(r, {4'(c), 12'h0ab});
        end
        pio(1'b0, 11'h7c0, 16'h0, r);
        chk(r, CTRL_RST);
        slot_dma_chan[2] <= 4'h3;
        slot_dma_chan[5] <= 4'h9;
        slot_dma_req <= 8'h24;
        for (int w = 0; w < 2; w++) begin
            s = w ? 5 : 2;
            for (int i = 0; i < 20 && mem_req !== 1'b1; i++) @(posedge mclk) #1;
            chk(16'(mem_req), 16'h1);
            chk(mem_addr, {w ? 4'h9 : 4'h3, 12'h0ab});
            chk(mem_wdata, slot_dma_wdata[s]);
            chk(16'(mem_we), 16'(slot_dma_we[s]));
            @(posedge mclk) mem_ack <= 1'b1;
            @(posedge mclk) mem_ack <= 1'b0;
            #1 chk(16'(slot_dma_gnt), 16'h1 << s);
            chk(loc_dma_rdata, mem_rdata);
            slot_dma_req[s] <= 1'b0;
        end
        pio(1'b0, 11'h7d3, 16'h0, r);
        chk(r, 16'h30ac);
        bus_disconnect <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk(16'(loc_bus_en), 16'h0);
        pio(1'b0, 11'h123, 16'h0, r);
        chk(r, 16'h0);
        pio(1'b0, 11'h7c1, 16'h0, r);
        chk(r, 16'h0020);
        close_out;
    end
    initial begin
        #500000;
        n_mismatch++;
        close_out;
    end
endmodule // local_io_bus_receiver_tb
